// File: verilog/crcl_pkg.sv
// Package with constants, carrier structs and step functions for the CRC16/LFSR32 engine
package crcl_pkg;

  localparam int          CRCL_DATA_W      = 8;
  localparam logic [15:0] CRCL_CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRCL_CRC_RESET   = 16'h0000;
  localparam logic [31:0] CRCL_LFSR_RESET  = 32'h0000_0000;
  localparam logic [7:0]  CRCL_BYTE_RESET  = 8'h00;
  localparam int          CRCL_TAP_A       = 31;
  localparam int          CRCL_TAP_B       = 29;
  localparam int          CRCL_TAP_C       = 25;
  localparam int          CRCL_TAP_D       = 24;
  localparam int          CRCL_CTRL_SRC    = 0;
  localparam int          CRCL_CTRL_TRIG   = 8;
  localparam int          CRCL_CTRL_W      = 16;
  localparam logic        CRCL_SRC_SW      = 1'b0;
  localparam logic        CRCL_SRC_STREAM  = 1'b1;

  typedef struct packed {
    logic                   strobe;
    logic [CRCL_DATA_W-1:0] data;
  } crcl_word_s;

  typedef struct packed {
    logic [15:0] crc;
    logic [31:0] lfsr;
    logic        crc_done;
    logic        lfsr_done;
  } crcl_result_s;

  // One byte into the CRC, most significant bit first
  function automatic logic [15:0] crcl_crc_byte(input logic [15:0] crc,
                                                input logic [CRCL_DATA_W-1:0] d);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = CRCL_DATA_W - 1; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c  = {c[14:0], 1'b0} ^ (fb ? CRCL_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // One shift of the LFSR; the source bit is folded into the feedback
  function automatic logic [31:0] crcl_lfsr_step(input logic [31:0] s, input logic din);
    logic nb;
    nb = s[CRCL_TAP_A] ^ s[CRCL_TAP_B] ^ s[CRCL_TAP_C] ^ s[CRCL_TAP_D] ^ din;
    return {s[30:0], nb};
  endfunction

endpackage

// File: verilog/crcl_engine.sv
// CRC16 calculator and 32-bit LFSR engine
`timescale 1ns/1ps

module crcl_engine (
  // Clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                reset_n,
  // Control word: bit 0 source select, bit 8 LFSR trigger
  input  wire logic [crcl_pkg::CRCL_CTRL_W-1:0]    lfsr_crc_control,
  // Software data write
  input  wire crcl_pkg::crcl_word_s                crc_data_in,
  // Alternate data source
  input  wire crcl_pkg::crcl_word_s                stream_in,
  // Results
  output crcl_pkg::crcl_result_s                   result
);

  logic [15:0]           crc_result_reg;
  logic [31:0]           lfsr_result_reg;
  logic                  crc_done_reg;
  logic                  lfsr_done_reg;
  logic                  trig_seen_reg;
  logic [7:0]            lfsr_byte_reg;
  logic                  src_stream;
  logic                  trig_rise;
  crcl_pkg::crcl_word_s  sel_word;
  // Byte-wide reference CRC, used only by the checks below
  logic [7:0]            crc_fold;
  logic [7:0]            crc_mix;
  logic [15:0]           crc_shadow_next;
  logic [15:0]           crc_shadow_reg;

  // The source must be settled before data arrives; a change mid-stream just retargets
  assign src_stream = lfsr_crc_control[crcl_pkg::CRCL_CTRL_SRC];
  assign sel_word   = (src_stream == crcl_pkg::CRCL_SRC_STREAM) ? stream_in : crc_data_in;

  // Trigger acts on the rising edge so a bit left high does not free-run the LFSR
  assign trig_rise  = lfsr_crc_control[crcl_pkg::CRCL_CTRL_TRIG] & ~trig_seen_reg;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      trig_seen_reg <= 1'b0;
    end else begin
      trig_seen_reg <= lfsr_crc_control[crcl_pkg::CRCL_CTRL_TRIG];
    end
  end

  // CRC accumulator, one byte per accepted strobe
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      crc_result_reg <= crcl_pkg::CRCL_CRC_RESET;
      crc_done_reg   <= 1'b0;
    end else begin
      crc_done_reg <= sel_word.strobe;
      if (sel_word.strobe) begin
        crc_result_reg <= crcl_pkg::crcl_crc_byte(crc_result_reg,
                                                  sel_word.data);
      end
    end
  end

  // Last byte of the selected source feeds the LFSR input bit
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lfsr_byte_reg <= crcl_pkg::CRCL_BYTE_RESET;
    end else if (sel_word.strobe) begin
      lfsr_byte_reg <= sel_word.data;
    end
  end

  // LFSR state; a zero state with zero input stays zero, so seed it through data
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lfsr_result_reg <= crcl_pkg::CRCL_LFSR_RESET;
      lfsr_done_reg   <= 1'b0;
    end else begin
      lfsr_done_reg <= trig_rise;
      if (trig_rise) begin
        lfsr_result_reg <= crcl_pkg::crcl_lfsr_step(lfsr_result_reg,
                                                    lfsr_byte_reg[0]);
      end
    end
  end

  // Every result field is a register, so readers never see a half-updated value
  assign result = '{crc:       crc_result_reg,
                    lfsr:      lfsr_result_reg,
                    crc_done:  crc_done_reg,
                    lfsr_done: lfsr_done_reg};

  // Byte-at-a-time form of the same generator; it shares no code with the bit-serial
  // loop, so a slip in either one shows up as a disagreement between the two
  always_comb begin
    crc_fold        = crc_shadow_reg[15:8] ^ sel_word.data;
    crc_mix         = crc_fold ^ {4'h0, crc_fold[7:4]};
    crc_shadow_next = {crc_shadow_reg[7:0], 8'h00} ^ {crc_mix[3:0], 12'h000}
                    ^ {3'h0, crc_mix, 5'h00} ^ {8'h00, crc_mix};
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      crc_shadow_reg <= crcl_pkg::CRCL_CRC_RESET;
    end else if (sel_word.strobe) begin
      crc_shadow_reg <= crc_shadow_next;
    end
  end

  // CRC update uses the exact generator
  crc_poly_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(sel_word.strobe) && $past(reset_n) |->
      crc_result_reg == crcl_pkg::crcl_crc_byte($past(crc_result_reg), $past(sel_word.data)))
    else $error("CRC value does not match generator");

  lfsr_taps_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    trig_rise |=> lfsr_result_reg[0] == ($past(lfsr_result_reg[31]) ^ $past(lfsr_result_reg[29])
      ^ $past(lfsr_result_reg[25]) ^ $past(lfsr_result_reg[24]) ^ $past(lfsr_byte_reg[0])))
    else $error("LFSR feedback bit wrong");

  lfsr_shift_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    trig_rise |=> lfsr_result_reg[31:1] == $past(lfsr_result_reg[30:0]))
    else $error("LFSR did not shift by one");

  crc_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !sel_word.strobe |=> $stable(crc_result_reg))
    else $error("CRC changed without a write");

  crc_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sel_word.strobe |=> result.crc_done ##1 (result.crc_done == $past(sel_word.strobe)))
    else $error("CRC done pulse misplaced");

  lfsr_once_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    trig_rise |=> !trig_rise)
    else $error("LFSR stepped twice for one trigger");

  lfsr_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !trig_rise |=> !result.lfsr_done && $stable(lfsr_result_reg))
    else $error("LFSR result changed without trigger");

  reset_clear_a: assert property (@(posedge sys_clk)
    !reset_n |=> result.crc == 16'h0000 && result.lfsr == 32'h0000_0000 && !trig_seen_reg)
    else $error("State not cleared by reset");

  // The bit-serial update must agree with the byte-wide reference at every edge
  crc_shadow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    crc_result_reg == crc_shadow_reg)
    else $error("CRC differs from the byte-wide reference");

  // A stream strobe must be ignored entirely while software data is selected
  soft_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !lfsr_crc_control[crcl_pkg::CRCL_CTRL_SRC] && !crc_data_in.strobe
      |=> $stable(crc_result_reg) && $stable(lfsr_byte_reg) && !result.crc_done)
    else $error("Stream strobe changed state while software source selected");

  // A software strobe must be ignored entirely while the stream is selected
  stream_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lfsr_crc_control[crcl_pkg::CRCL_CTRL_SRC] && !stream_in.strobe
      |=> $stable(crc_result_reg) && $stable(lfsr_byte_reg) && !result.crc_done)
    else $error("Software strobe changed state while stream source selected");

  // The LFSR input bit follows the byte taken from the stream when it is selected
  stream_byte_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lfsr_crc_control[crcl_pkg::CRCL_CTRL_SRC] && stream_in.strobe
      |=> lfsr_byte_reg == $past(stream_in.data))
    else $error("LFSR input byte not taken from the stream source");

  // Likewise for software writes when the software source is selected
  soft_byte_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !lfsr_crc_control[crcl_pkg::CRCL_CTRL_SRC] && crc_data_in.strobe
      |=> lfsr_byte_reg == $past(crc_data_in.data))
    else $error("LFSR input byte not taken from the software source");

  // From an all-zero state the injected bit is the only one that can appear
  lfsr_inject_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    trig_rise && lfsr_result_reg == crcl_pkg::CRCL_LFSR_RESET
      |=> lfsr_result_reg == {31'h0, $past(lfsr_byte_reg[0])})
    else $error("LFSR step from zero state produced stray bits");

  // Every fresh rising edge of the trigger bit produces a step
  trig_edge_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(reset_n) && lfsr_crc_control[crcl_pkg::CRCL_CTRL_TRIG]
      && !$past(lfsr_crc_control[crcl_pkg::CRCL_CTRL_TRIG]) |=> result.lfsr_done)
    else $error("Trigger edge did not start an LFSR step");

  // A trigger bit left high must not keep stepping the register
  trig_held_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(reset_n) && lfsr_crc_control[crcl_pkg::CRCL_CTRL_TRIG]
      && $past(lfsr_crc_control[crcl_pkg::CRCL_CTRL_TRIG]) |=> !result.lfsr_done)
    else $error("Held trigger stepped the LFSR again");

  // The LFSR completion flag is a single-cycle pulse
  lfsr_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    result.lfsr_done |=> !result.lfsr_done)
    else $error("LFSR done held longer than one cycle");

  // Software may read the LFSR result at any time between steps
  lfsr_stand_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !result.lfsr_done |-> $stable(result.lfsr))
    else $error("LFSR result moved without a done pulse");

  // Likewise the CRC result stands between updates
  crc_stand_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !result.crc_done |-> $stable(result.crc))
    else $error("CRC result moved without a done pulse");

  // No accepted byte, no completion pulse
  crc_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !sel_word.strobe |=> !result.crc_done)
    else $error("CRC done pulsed without an accepted byte");

  // Completion pulses from before reset must not leak out of it
  reset_done_a: assert property (@(posedge sys_clk)
    !reset_n |=> !result.crc_done && !result.lfsr_done)
    else $error("Done pulse present during reset");

endmodule

// File: test/crcl_engine_tb.sv
// Self-checking testbench for the CRC16/LFSR32 engine
`timescale 1ns/1ps
module crcl_engine_tb;
  logic                   sys_clk     = 1'b0;
  logic                   reset_n     = 1'b0;
  logic [15:0]            ctrl        = 16'h0000;
  crcl_pkg::crcl_word_s   din         = '0;
  crcl_pkg::crcl_word_s   sin         = '0;
  crcl_pkg::crcl_result_s res;
  int                     errors      = 0;
  int                     comparisons = 0;
  logic [15:0]            ecrc;
  logic [31:0]            elfsr;

  always #5 sys_clk = ~sys_clk;

  crcl_engine u_crcl_engine (
    .sys_clk          (sys_clk),
    .reset_n          (reset_n),
    .lfsr_crc_control (ctrl),
    .crc_data_in      (din),
    .stream_in        (sin),
    .result           (res)
  );

  function automatic logic [15:0] ref_crc(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Trigger bit is low here, so release is not taken as a trigger edge
  task automatic t_reset();
    reset_n = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk(res, '0);
    reset_n = 1'b1;
    $display("Reset test done");
  endtask

  // Strobe held high: one byte per cycle, checked as each lands
  task automatic t_crc();
    string s = "123456789";
    ecrc = 16'h0000;
    din.strobe = 1'b1;
    for (int i = 0; i < s.len(); i++) begin
      din.data = s[i];
      @(negedge sys_clk);
      ecrc = ref_crc(ecrc, s[i]);
      chk(res.crc_done, 1'b1);
      chk(res.crc, ecrc);
    end
    din.strobe = 1'b0;
    @(negedge sys_clk);
    chk(res.crc_done, 1'b0);
    chk(res.crc, 16'h31c3);
    $display("CRC test done");
  endtask

  // Last byte taken had bit 0 set, so each step injects a one; 40 steps reach the taps
  task automatic t_lfsr();
    elfsr = 32'h0000_0000;
    for (int k = 0; k < 40; k++) begin
      ctrl[8] = 1'b1;
      @(negedge sys_clk);
      elfsr = {elfsr[30:0], elfsr[31] ^ elfsr[29] ^ elfsr[25] ^ elfsr[24] ^ 1'b1};
      chk(res.lfsr_done, 1'b1);
      chk(res.lfsr, elfsr);
      @(negedge sys_clk);
      chk(res.lfsr_done, 1'b0);
      chk(res.lfsr, elfsr);
      ctrl[8] = 1'b0;
      @(negedge sys_clk);
    end
    $display("LFSR test done");
  endtask

  task automatic t_src();
    ctrl[0] = 1'b1;
    din = {1'b1, 8'haa};
    sin = {1'b1, 8'h5b};
    @(negedge sys_clk);
    ecrc = ref_crc(ecrc, 8'h5b);
    chk(res.crc_done, 1'b1);
    chk(res.crc, ecrc);
    sin.strobe = 1'b0;
    @(negedge sys_clk);
    chk(res.crc_done, 1'b0);
    chk(res.crc, ecrc);
    ctrl[0] = 1'b0;
    din.strobe = 1'b0;
    sin.strobe = 1'b1;
    @(negedge sys_clk);
    chk(res.crc_done, 1'b0);
    chk(res.crc, ecrc);
    sin.strobe = 1'b0;
    $display("Source test done");
  endtask

  // Trigger high as reset lifts counts as an edge: one step from zero, then none while held
  task automatic t_trig_reset();
    ctrl = 16'h0100;
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(res, '0);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chk(res.lfsr_done, 1'b1);
    chk(res.lfsr, 32'h0000_0000);
    repeat (2) @(negedge sys_clk);
    chk(res.lfsr_done, 1'b0);
    chk(res.lfsr, 32'h0000_0000);
    ctrl = 16'h0000;
    @(negedge sys_clk);
    $display("Trigger reset test done");
  endtask

  initial begin
    t_reset();
    t_crc();
    t_lfsr();
    t_src();
    t_trig_reset();
    t_reset();
    finish_test();
  end

  // About 180 cycles are needed; allow 1000, over five times that
  initial begin
    #10000;
    errors++;
    finish_test();
  end
endmodule
